//--- core/bzd_pkg.sv
// Package: constants, states and configuration carrier of the demag / zero-cross detector
package bzd_pkg;

  // ----------------------------------------------------------------
  // Clock and window timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned ZW_SHORT_STEP_US = 5;   // Codes 0..7 step
  localparam int unsigned ZW_LONG_BASE_US = 40;   // Codes 8..15 base
  localparam int unsigned ZW_LONG_STEP_US = 20;   // Codes 8..15 step
  localparam int unsigned WIN_W = 13;             // Holds 200 us of cycles

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLD_W = 4;
  localparam int unsigned CNT_W = 5;              // Counts up to 16
  localparam int unsigned TMR_W_DEF = 8;
  localparam int unsigned ZFR_WIN_LSB = 4;        // Window field position
  localparam int unsigned ZFR_CNT_LSB = 0;        // Event count field position
  localparam logic [7:0] ZFR_RST = 8'hF0;         // 200 us window, limit of one
  localparam int unsigned SDIV_W = 3;             // Sample divider width

  // ----------------------------------------------------------------
  // Sequence states and configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DWAIT,
    ST_ZBLANK,
    ST_ZWAIT
  } bzd_state_e;

  typedef struct packed {
    logic position_sensor_mode_bit;
    logic detection_polarity_relation_bit;
    logic comparator_edge_bit;
    logic hw_demag_capture_enable;
    logic sim_demag_enable;
  } bzd_cfg_s;

endpackage : bzd_pkg

//--- core/bzd_evfilt.sv
// Consecutive-sample event counter used for both demag and zero-cross qualification
`timescale 1ns/100ps
module bzd_evfilt (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic sample_i,
  input wire logic hit_i,
  input wire logic [bzd_pkg::FLD_W-1:0] limit_i,
  // Result
  output logic reached_o,
  output logic [bzd_pkg::CNT_W-1:0] count_o
);
  import bzd_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign reached_o = sample_i && hit_i && (cnt_q == {1'b0, limit_i});
  assign count_o = cnt_q;

  // Next count: restart on clear or on a non-qualifying sample
  always_comb begin
    cnt_d = cnt_q;
    if (clr_i || reached_o) begin
      cnt_d = '0;
    end else if (sample_i) begin
      cnt_d = hit_i ? cnt_q + 5'h01 : '0;
    end
  end

  // Counter register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : bzd_evfilt

//--- core/bzd_detector.sv
// Demagnetization and zero-crossing event detector with blanking window and filters
`timescale 1ns/100ps
// Summary of operation
// - Each demag event starts a zero-cross blanking window that hides crossings.
// - Window codes 0-7 give 5-40 us, codes 8-15 give 60-200 us.
// - After reset the window setting is the 200 us maximum.
// - Outside sensor mode, blanking is armed after hardware and software commutations alike.
// - After blanking, consecutive qualifying samples are counted before flagging zero cross.
// - Count field limit is field value plus one, 1 to 16, reset 1.
// - Comparator sampling rate is software selectable.
// - Simulated zero crossings bypass the counter: limit fixed at one.
// - Relation and edge bits choose the qualifying levels of both events.
// - Hardware demag is a comparator edge qualified by its own sample counter.
// - With capture enabled, hardware demag copies the timer into the delay register.
// - With simulation enabled, timer matching delay register raises demag.
// - With both sources on, the first one produces the step's demag.
// - Any demag sets the sticky demag flag; mask gates the request.
// - With simulation enabled, right after commutation, delay at or below timer gives demag now.
// - Outside sensor mode each step runs commutation, then demag, then zero cross, in order.
module bzd_detector #(
  parameter int unsigned TMR_W = bzd_pkg::TMR_W_DEF,
  parameter int unsigned ZW_CYC_PER_US = bzd_pkg::CYC_PER_US
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Mode configuration
  input wire bzd_pkg::bzd_cfg_s cfg_i,
  input wire logic [1:0] sample_rate_sel_i,
  input wire logic [bzd_pkg::FLD_W-1:0] demag_event_count_field_i,
  input wire logic demag_interrupt_mask_i,
  // Zero cross filter register write port
  input wire logic zfr_wr_i,
  input wire logic [7:0] zfr_wdata_i,
  // Demag delay register write port
  input wire logic ddr_wr_i,
  input wire logic [TMR_W-1:0] ddr_wdata_i,
  // Motor side events and comparator
  input wire logic commutation_i,
  input wire logic phase_sense_cmp_i,
  input wire logic sim_zero_cross_i,
  input wire logic [TMR_W-1:0] motor_step_timer_i,
  // Flag clears
  input wire logic demag_flag_clr_i,
  input wire logic zc_flag_clr_i,
  // Events and status
  output logic demag_event_o,
  output logic zc_event_o,
  output logic demag_interrupt_flag_o,
  output logic zc_flag_o,
  output logic demag_irq_o,
  output logic [7:0] zero_cross_filter_register_o,
  output logic [TMR_W-1:0] demag_delay_register_o,
  output bzd_pkg::bzd_state_e state_o
);
  import bzd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bzd_state_e state_q, state_d;
  logic [WIN_W-1:0] blank_q, blank_d, win_cyc;
  logic [7:0] zfr_q, zfr_d;
  logic [TMR_W-1:0] ddr_q, ddr_d;
  logic [SDIV_W-1:0] sdiv_q, sdiv_d;
  logic check_q, check_d;
  logic dflag_q, dflag_d, zflag_q, zflag_d;
  logic sample, z_level, d_level, prev_cmp_q, prev_cmp_d;
  logic d_reached, z_reached, hw_d, sim_d, chk_d, hw_z;
  logic [CNT_W-1:0] z_count, d_count;
  int unsigned win_us;

  // ----------------------------------------------------------------
  // Sampling and polarity
  // ----------------------------------------------------------------
  // selectable rate
  always_comb begin
    sample = (sdiv_q == SDIV_W'((1 << sample_rate_sel_i) - 1));
    sdiv_d = sample ? '0 : sdiv_q + 3'h1;
  end

  always_comb begin
    z_level = ~cfg_i.comparator_edge_bit;
    d_level = cfg_i.detection_polarity_relation_bit ? z_level : ~z_level;
  end

  // demag seen only after the comparator moved onto the demag level from the other level
  bzd_evfilt u_dfilt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(state_q != ST_DWAIT),
    .sample_i(sample),
    .hit_i(phase_sense_cmp_i == d_level && (prev_cmp_q != d_level || d_count != '0)),
    .limit_i(demag_event_count_field_i),
    .reached_o(d_reached),
    .count_o(d_count)
  );

  bzd_evfilt u_zfilt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(state_q != ST_ZWAIT),
    .sample_i(sample),
    .hit_i(phase_sense_cmp_i == z_level),
    .limit_i(zfr_q[ZFR_CNT_LSB +: FLD_W]),
    .reached_o(z_reached),
    .count_o(z_count)
  );

  // ----------------------------------------------------------------
  // Window length
  // ----------------------------------------------------------------
  // code to cycles
  always_comb begin
    win_us = zfr_q[ZFR_WIN_LSB + 3] ?
      ZW_LONG_BASE_US + (int'(zfr_q[ZFR_WIN_LSB +: 3]) + 1) * ZW_LONG_STEP_US :
      (int'(zfr_q[ZFR_WIN_LSB +: 3]) + 1) * ZW_SHORT_STEP_US;
    win_cyc = WIN_W'(win_us * ZW_CYC_PER_US);
  end

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  // hardware, match and post-commutation check race; first wins
  always_comb begin
    hw_d = (state_q == ST_DWAIT) && d_reached &&
           (cfg_i.hw_demag_capture_enable || !cfg_i.sim_demag_enable);
    sim_d = (state_q == ST_DWAIT) && cfg_i.sim_demag_enable &&
            (motor_step_timer_i == ddr_q);
    chk_d = (state_q == ST_DWAIT) && check_q && cfg_i.sim_demag_enable &&
            (ddr_q <= motor_step_timer_i);
    demag_event_o = (hw_d || sim_d || chk_d) && !commutation_i;
    hw_z = (state_q == ST_ZWAIT) && z_reached;
    // simulated crossing needs one event only
    zc_event_o = (state_q == ST_ZWAIT) && (hw_z || sim_zero_cross_i) && !commutation_i;
  end

  // ----------------------------------------------------------------
  // Step sequence
  // ----------------------------------------------------------------
  // commutation, demag, zero cross
  always_comb begin
    state_d = state_q;
    blank_d = blank_q;
    check_d = 1'b0;
    prev_cmp_d = sample ? phase_sense_cmp_i : prev_cmp_q;
    if (commutation_i) begin
      // any commutation re-arms; sensor mode skips demag and blanking
      state_d = cfg_i.position_sensor_mode_bit ? ST_ZWAIT : ST_DWAIT;
      check_d = !cfg_i.position_sensor_mode_bit;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_DWAIT: begin
          if (demag_event_o) begin
            state_d = ST_ZBLANK;
            blank_d = win_cyc;
          end
        end
        ST_ZBLANK: begin
          blank_d = blank_q - 13'h0001;
          if (blank_q <= 13'h0001) begin
            state_d = ST_ZWAIT;
          end
        end
        ST_ZWAIT: begin
          if (zc_event_o) begin
            state_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software and hardware
  // ----------------------------------------------------------------
  always_comb begin
    zfr_d = zfr_wr_i ? zfr_wdata_i : zfr_q;
    ddr_d = ddr_q;
    if (ddr_wr_i) begin
      ddr_d = ddr_wdata_i;
    end
    if (hw_d && cfg_i.hw_demag_capture_enable && demag_event_o) begin
      ddr_d = motor_step_timer_i;
    // overwrite with timer on late delay
    end else if (chk_d && demag_event_o) begin
      ddr_d = motor_step_timer_i;
    end
    dflag_d = demag_event_o || (dflag_q && !demag_flag_clr_i);
    zflag_d = zc_event_o || (zflag_q && !zc_flag_clr_i);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      blank_q <= '0;
      zfr_q <= ZFR_RST;
      ddr_q <= '0;
      sdiv_q <= '0;
      check_q <= 1'b0;
      dflag_q <= 1'b0;
      zflag_q <= 1'b0;
      prev_cmp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      blank_q <= blank_d;
      zfr_q <= zfr_d;
      ddr_q <= ddr_d;
      sdiv_q <= sdiv_d;
      check_q <= check_d;
      dflag_q <= dflag_d;
      zflag_q <= zflag_d;
      prev_cmp_q <= prev_cmp_d;
    end
  end

  // Outputs
  assign demag_interrupt_flag_o = dflag_q;
  assign zc_flag_o = zflag_q;
  assign demag_irq_o = dflag_q && demag_interrupt_mask_i;
  assign zero_cross_filter_register_o = zfr_q;
  assign demag_delay_register_o = ddr_q;
  assign state_o = state_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_blank_start;
    demag_event_o && !cfg_i.position_sensor_mode_bit
      |=> state_q == ST_ZBLANK && blank_q == $past(win_cyc);
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("window not opened");

  property p_blank_quiet;
    state_q == ST_ZBLANK |-> !zc_event_o;
  endproperty
  a_blank_quiet: assert property (p_blank_quiet) else $error("crossing inside window");

  property p_win_code;
    zfr_q[7:4] == 4'hF |-> win_cyc == WIN_W'(200 * ZW_CYC_PER_US);
  endproperty
  a_win_code: assert property (p_win_code) else $error("window code wrong");

  property p_reset_zfr;
    $fell(rst_i) |-> zfr_q == ZFR_RST;
  endproperty
  a_reset_zfr: assert property (p_reset_zfr) else $error("filter reset wrong");

  property p_sensor_skip;
    commutation_i && cfg_i.position_sensor_mode_bit |=> state_q == ST_ZWAIT;
  endproperty
  a_sensor_skip: assert property (p_sensor_skip) else $error("sensor mode blanked");

  property p_zc_count;
    hw_z |-> z_count == {1'b0, zfr_q[3:0]} && phase_sense_cmp_i == z_level;
  endproperty
  a_zc_count: assert property (p_zc_count) else $error("crossing before limit");

  property p_sim_zc;
    sim_zero_cross_i && state_q == ST_ZWAIT && !commutation_i |-> zc_event_o;
  endproperty
  a_sim_zc: assert property (p_sim_zc) else $error("simulated crossing lost");

  property p_capture;
    hw_d && demag_event_o && cfg_i.hw_demag_capture_enable
      |=> ddr_q == $past(motor_step_timer_i);
  endproperty
  a_capture: assert property (p_capture) else $error("timer not captured");

  property p_sim_match;
    state_q == ST_DWAIT && cfg_i.sim_demag_enable && !commutation_i &&
      motor_step_timer_i == ddr_q |-> demag_event_o ##1 state_q == ST_ZBLANK ||
      cfg_i.position_sensor_mode_bit;
  endproperty
  a_sim_match: assert property (p_sim_match) else $error("match missed");

  property p_flag_irq;
    demag_event_o |=> dflag_q ##0 (demag_irq_o == demag_interrupt_mask_i);
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("demag flag not set");

  property p_check;
    commutation_i && cfg_i.sim_demag_enable && !cfg_i.position_sensor_mode_bit
      ##1 (ddr_q <= motor_step_timer_i && !commutation_i) |-> demag_event_o;
  endproperty
  a_check: assert property (p_check) else $error("late delay not caught");

  property p_order;
    zc_event_o |-> state_q == ST_ZWAIT ##1 state_q == ST_IDLE;
  endproperty
  a_order: assert property (p_order) else $error("event out of order");

endmodule : bzd_detector

//--- verif/bzd_phase_model.sv
// Phase comparator model: follows the commanded winding level after a lag
`timescale 1ns/100ps
module bzd_phase_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Commanded winding level and lag in cycles
  input wire logic level_i,
  input wire logic [3:0] lag_i,
  // Comparator output
  output logic cmp_o
);
  logic [3:0] cnt_q;
  // Output settles lag plus one cycles after the winding level changes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_o <= 1'b0;
      cnt_q <= 4'h0;
    end else if (level_i == cmp_o) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= lag_i) begin
      cmp_o <= level_i;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : bzd_phase_model

//--- verif/tb_top.sv
// Self-checking bench of the demag and zero-cross detector
`timescale 1ns/100ps
module tb_top;
  import bzd_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  bzd_cfg_s cfg = '0;
  logic [1:0] sel = 2'h0;
  logic [3:0] dcnt = 4'h0, lag = 4'h0;
  logic mask = 1'b0, zwr = 1'b0, dwr = 1'b0, comm = 1'b0, simz = 1'b0, dclr = 1'b0, zclr = 1'b0;
  logic lvl = 1'b0, cmp, dm_ev, zc_ev, dflag, zflag, irq, dp = 1'b0, zp = 1'b0;
  logic [7:0] zwd = 8'h00, dwd = 8'h00, tmr = 8'h00, start = 8'h00, zfr_q, ddr_q, ex_ddr;
  bzd_state_e st;
  int fails = 0, n_tests = 0, dw_n = 0, zw_n = 0, bl_n = 0, lo, hi;
  int q_win[$], q_dlo[$], q_dhi[$], q_zlo[$], q_zhi[$];

  // Device under test and the comparator in front of it
  bzd_detector #(.TMR_W(8), .ZW_CYC_PER_US(1)) u_bzd_detector (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_i(cfg), .sample_rate_sel_i(sel),
    .demag_event_count_field_i(dcnt), .demag_interrupt_mask_i(mask), .zfr_wr_i(zwr),
    .zfr_wdata_i(zwd), .ddr_wr_i(dwr), .ddr_wdata_i(dwd), .commutation_i(comm),
    .phase_sense_cmp_i(cmp), .sim_zero_cross_i(simz), .motor_step_timer_i(tmr),
    .demag_flag_clr_i(dclr), .zc_flag_clr_i(zclr), .demag_event_o(dm_ev), .zc_event_o(zc_ev),
    .demag_interrupt_flag_o(dflag), .zc_flag_o(zflag), .demag_irq_o(irq),
    .zero_cross_filter_register_o(zfr_q), .demag_delay_register_o(ddr_q), .state_o(st));
  bzd_phase_model u_bzd_phase_model (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .level_i(lvl), .lag_i(lag), .cmp_o(cmp));

  // Clock and motor step timer, reloaded on commutation
  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) tmr <= comm ? start : tmr + 8'h01;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  function automatic int wcyc(input logic [3:0] c);
    return (c < 4'h8) ? (int'(c) + 1) * 5 : 40 + (int'(c) - 7) * 20;
  endfunction : wcyc

  // Result monitor: takes the oldest note whenever an event appears
  always @(posedge core_clk_i) begin
    if (!rst_i) begin
      if (dp) chk("delay_reg", ddr_q, ex_ddr);
      if (dp) chk("demag_flag_irq", {dflag, irq}, {1'b1, mask});
      if (zp) chk("zc_flag", zflag, 1'b1);
      dp = dm_ev;
      zp = zc_ev;
      if (dm_ev) begin
        ex_ddr = tmr;
        lo = q_dlo.size() ? q_dlo.pop_front() : 1;
        hi = q_dhi.size() ? q_dhi.pop_front() : 0;
        chk("demag_time", dw_n >= lo && dw_n <= hi, 1'b1);
      end
      if (zc_ev) begin
        lo = q_zlo.size() ? q_zlo.pop_front() : 1;
        hi = q_zhi.size() ? q_zhi.pop_front() : 0;
        chk("zc_time", zw_n >= lo && zw_n <= hi, 1'b1);
      end
      if (st == ST_ZBLANK) bl_n++;
      else if (bl_n > 0) begin
        chk("window", bl_n, q_win.size() ? q_win.pop_front() : 0);
        bl_n = 0;
      end
      if (st == ST_DWAIT) dw_n++;
      if (st == ST_ZWAIT) zw_n++;
      if (comm) begin
        dw_n = 0;
        zw_n = 0;
      end
    end
  end

  // One motor step: configure, note expectations, commutate, steer the comparator
  task automatic step(input bzd_cfg_s c, input logic [3:0] wc, zc, input bit wr,
                      input int kind, input int szc);
    int z, d, s, l, n, k, sl, dc;
    z = !c.comparator_edge_bit;
    d = c.detection_polarity_relation_bit ? z : !z;
    s = 20 + $urandom_range(30);
    l = 8 + $urandom_range(7);
    n = wr ? int'(zc) + 1 : 1;
    sl = kind == 0 ? $urandom_range(3) : 0;
    dc = $urandom_range(3);
    @(posedge core_clk_i);
    cfg <= c;
    zwr <= wr;
    zwd <= {wc, zc};
    dwr <= 1'b1;
    // both sources: delay well after the hardware edge
    // simulation only: delay longer than the comparator lag, or below the start value for the late-delay step
    // delay written only while idle, never near a capture
    dwd <= 8'(kind == 2 ? s - 1 - $urandom_range(15) : kind == 3 ? s + 150 : s + l + 5);
    start <= 8'(s);
    sel <= 2'(sl);
    dcnt <= 4'(dc);
    mask <= 1'($urandom_range(1));
    lvl <= kind == 4 ? !z : !d;
    lag <= 4'h0;
    {dclr, zclr} <= 2'h3;
    @(posedge core_clk_i);
    {zwr, dwr, dclr, zclr} <= 4'h0;
    lag <= 4'(l);
    if (kind != 4) q_win.push_back(wcyc(wr ? wc : 4'hF));
    if (kind == 0 || kind == 3) q_dlo.push_back(l + (dc << sl));
    if (kind == 0 || kind == 3) q_dhi.push_back(l + 3 + ((dc + 1) << sl));
    if (kind == 1 || kind == 2) q_dlo.push_back(kind == 1 ? l + 5 : 0);
    if (kind == 1 || kind == 2) q_dhi.push_back(kind == 1 ? l + 5 : 0);
    q_zlo.push_back(szc == 2 ? 0 : ((n - 1) << sl) - 1);
    q_zhi.push_back(szc == 2 ? 3 : ((n + 1) << sl) + 2 + (kind == 4 ? l : 0));
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("flags_clear", {dflag, zflag, irq}, 3'h0);
    if (wr) chk("zfr_write", zfr_q, {wc, zc});
    @(posedge core_clk_i);
    comm <= 1'b1;
    @(posedge core_clk_i);
    comm <= 1'b0;
    if (kind == 0 || kind == 3) lvl <= d;
    if (kind == 4) lvl <= z;
    @(negedge core_clk_i);
    chk("state", st, kind == 4 ? ST_ZWAIT : ST_DWAIT);
    for (k = 0; k < 400 && kind != 4 && st !== ST_ZBLANK; k++) @(negedge core_clk_i);
    @(posedge core_clk_i);
    if (szc != 2) lvl <= z;
    lag <= 4'h0;
    for (k = 0; k < 400 && szc == 2 && st !== ST_ZWAIT; k++) @(negedge core_clk_i);
    @(posedge core_clk_i);
    simz <= szc != 0;
    @(posedge core_clk_i);
    simz <= 1'b0;
    for (k = 0; k < 900 && st !== ST_IDLE; k++) @(negedge core_clk_i);
    chk("step_done", k < 900, 1'b1);
  endtask : step

  // Main sequence
  initial begin
    void'($urandom(32'h7FC1));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("reset_regs", {zfr_q, ddr_q, 6'(st), dflag, zflag}, {8'hF0, 8'h00, 8'h00});
    step(5'b00010, 4'h0, 4'h0, 1'b0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      step({1'b0, 2'(i), 2'b10}, 4'($urandom_range(15)), 4'($urandom_range(15)), 1'b1, 0, 0);
    end
    for (int i = 7; i < 9; i++) step(5'b00001, 4'(i), 4'h0, 1'b1, 1, 0);
    step(5'b00001, 4'h1, 4'h0, 1'b1, 2, 0);
    step(5'b00011, 4'h2, 4'h1, 1'b1, 3, 0);
    step(5'b00010, 4'h0, 4'h3, 1'b1, 0, 1);
    step(5'b00010, 4'h0, 4'hF, 1'b1, 0, 2);
    step(5'b10000, 4'h0, 4'h2, 1'b1, 4, 0);
    close_out;
  end

  // Watchdog against a hang
  initial begin
    #1000000;
    fails++;
    close_out;
  end
endmodule : tb_top
